// ==== hw/ebtsp_pkg.sv ====
package ebtsp_pkg;

	// ****************************************
	// Register map (printed offsets not all word multiples: index x4)
	// ****************************************
	localparam logic [11:0] TIMER_COUNT_IDX = 12'h001; // Count register index
	localparam logic [11:0] INTERRUPT_CONTROL_IDX = 12'h00B; // Interrupt control index
	localparam logic [11:0] OPTION_CONFIG_IDX = 12'h081; // Option register index
	localparam logic [11:0] IRQ_STATUS_IDX = 12'h100; // Sticky event status index
	localparam logic [11:0] IRQ_CLEAR_IDX = 12'h101; // Write-one-to-clear index
	localparam logic [11:0] IRQ_ENABLE_IDX = 12'h102; // Event enable index
	localparam logic [11:0] CORE_CTRL_IDX = 12'h103; // Sleep and watchdog-clear index

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] TIMER_COUNT_RST = 8'h00; // Count after reset
	localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h00; // Enables and flag cleared
	localparam logic [7:0] OPTION_CONFIG_RST = 8'hFF; // Option after reset

	// ****************************************
	// Field positions
	// ****************************************
	localparam int unsigned OPT_SOURCE_SEL_BIT = 5; // Count source select
	localparam int unsigned OPT_EDGE_SEL_BIT = 4; // Source edge select
	localparam int unsigned OPT_ASSIGN_BIT = 3; // Prescaler to watchdog when set
	localparam int unsigned IC_OVF_IE_BIT = 5; // Overflow irq enable
	localparam int unsigned IC_OVF_FLAG_BIT = 2; // Overflow flag
	localparam int unsigned CTRL_SLEEP_BIT = 0; // Sleep level
	localparam int unsigned CTRL_WDT_CLR_BIT = 1; // Watchdog-clear strobe

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned PHASES_PER_CYCLE = 4; // Q1..Q4 per instruction cycle
	localparam int unsigned WRITE_INHIBIT_CYCLES = 2; // Count holds after a write
	localparam logic [7:0] COUNT_MAX = 8'hFF; // Value before wrap

	// Prescaler control bundle
	typedef struct packed
	{
		logic to_watchdog; // Prescaler owner
		logic [2:0] ratio; // Division ratio field
	} ebtsp_presc_cfg_s;

endpackage

// ==== hw/ebtsp_prescaler.sv ====
`timescale 1ns/1ps

// Shared ripple-style prescaler modelled as a synchronous counter
module ebtsp_prescaler
#(
	parameter int unsigned WIDTH = 8
)
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic tick_i,
	input wire logic clear_i,
	input wire ebtsp_pkg::ebtsp_presc_cfg_s cfg_i,
	output logic tap_o
);

	logic [WIDTH-1:0] count_reg; // Hidden count, no software address
	logic [3:0] sel; // Tap index
	logic [WIDTH-1:0] mask; // Low stages that must all be set

	// Counter side divides by 2^(ratio+1), watchdog side by 2^ratio
	always_comb
	begin
		sel = cfg_i.to_watchdog ? {1'b0, cfg_i.ratio} : ({1'b0, cfg_i.ratio} + 4'h1);
		mask = (WIDTH'(1) << sel) - WIDTH'(1);
	end

	// Count edges, clear has priority
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i || clear_i)
			count_reg <= '0;
		else if (tick_i)
			count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
	end

	// Output fires when all selected stages carry; empty mask passes the input
	always_comb
	begin
		tap_o = tick_i && ((count_reg & mask) == mask);
	end

endmodule

// ==== hw/ebtsp_timer.sv ====
`timescale 1ns/1ps

module ebtsp_timer
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic ext_count_input_i,
	output logic watchdog_tick_o,
	output logic irq_o
);

	// ****************************************
	// Bus address phase capture
	// ****************************************
	logic wr_pend_reg; // Write data phase pending
	logic [11:0] wr_idx_reg; // Captured write index
	logic [31:0] hrdata_reg; // Read data
	logic addr_ok; // Word-aligned access
	logic take; // Address phase accepted
	logic [11:0] idx; // Register index

	assign take = hsel_i && hready_i && htrans_i[1];
	assign addr_ok = (haddr_i[1:0] == 2'h0) && (haddr_i[31:14] == 18'h00000);
	assign idx = addr_ok ? haddr_i[13:2] : 12'hFFF;

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] timer_count_reg; // Count value
	logic [7:0] interrupt_control_reg; // Enables and overflow flag
	logic [7:0] option_config_reg; // Source, edge, prescaler
	logic irq_status_reg; // Sticky overflow event
	logic irq_enable_reg; // Event enable
	logic sleep_reg; // Processor asleep
	logic irq_reg; // Registered interrupt
	logic [1:0] phase_reg; // Q phase, 0 = Q1
	logic [1:0] inhibit_reg; // Remaining held cycles
	logic [2:0] pin_sync_reg; // Three-stage pin sampler
	logic pin_level_reg; // Agreed pin level
	logic wdt_tick_reg; // Registered watchdog tick

	logic cyc_tick; // One pulse per instruction cycle
	logic q24; // Q2 or Q4 phase
	logic pin_edge; // Selected pin edge
	logic src_tick; // Raw event before prescaler
	logic presc_out; // Prescaler tap
	logic cnt_tick; // Increment enable for count
	logic wr_count; // Software write to count
	logic wr_opt; // Software write to option
	logic wdt_clr; // Watchdog clear instruction
	logic wrap; // Count wraps this cycle
	logic to_wdt; // Prescaler owned by watchdog
	ebtsp_pkg::ebtsp_presc_cfg_s presc_cfg; // Prescaler bundle

	assign wr_count = wr_pend_reg && (wr_idx_reg == ebtsp_pkg::TIMER_COUNT_IDX);
	assign wr_opt = wr_pend_reg && (wr_idx_reg == ebtsp_pkg::OPTION_CONFIG_IDX);
	assign wdt_clr = wr_pend_reg && (wr_idx_reg == ebtsp_pkg::CORE_CTRL_IDX)
		&& hwdata_i[ebtsp_pkg::CTRL_WDT_CLR_BIT];
	assign to_wdt = option_config_reg[ebtsp_pkg::OPT_ASSIGN_BIT];
	assign presc_cfg.to_watchdog = to_wdt;
	assign presc_cfg.ratio = option_config_reg[2:0];

	// ****************************************
	// Bus slave
	// ****************************************
	// Zero-wait slave: answers in the cycle after the address phase
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= 12'h000;
		end
		else
		begin
			wr_pend_reg <= take && hwrite_i;
			wr_idx_reg <= idx;
		end
	end

	// Read mux; prescaler count deliberately absent
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			hrdata_reg <= 32'h00000000;
		else if (take && !hwrite_i)
		begin
			case (idx)
				ebtsp_pkg::TIMER_COUNT_IDX: hrdata_reg <= {24'h000000, timer_count_reg};
				ebtsp_pkg::INTERRUPT_CONTROL_IDX: hrdata_reg <= {24'h000000, interrupt_control_reg};
				ebtsp_pkg::OPTION_CONFIG_IDX: hrdata_reg <= {24'h000000, option_config_reg};
				ebtsp_pkg::IRQ_STATUS_IDX: hrdata_reg <= {31'h00000000, irq_status_reg};
				ebtsp_pkg::IRQ_ENABLE_IDX: hrdata_reg <= {31'h00000000, irq_enable_reg};
				ebtsp_pkg::CORE_CTRL_IDX: hrdata_reg <= {31'h00000000, sleep_reg};
				default: hrdata_reg <= 32'h00000000;
			endcase
		end
	end

	assign hrdata_o = hrdata_reg;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	// ****************************************
	// Instruction-cycle phase clock
	// ****************************************
	// Q1..Q4 from the system clock; frozen during sleep
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			phase_reg <= 2'h0;
		else if (!sleep_reg)
			phase_reg <= phase_reg + 2'h1;
	end

	assign cyc_tick = !sleep_reg && (phase_reg == 2'(ebtsp_pkg::PHASES_PER_CYCLE - 1));
	assign q24 = !sleep_reg && phase_reg[0];

	// ****************************************
	// Pin synchroniser
	// ****************************************
	// Three flops; level moves when stage two and three agree
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			pin_sync_reg <= 3'h0;
			pin_level_reg <= 1'b0;
		end
		else
		begin
			pin_sync_reg <= {pin_sync_reg[1:0], ext_count_input_i};
			if (pin_sync_reg[1] == pin_sync_reg[2])
				pin_level_reg <= pin_sync_reg[2];
		end
	end

	// Edge of the agreed level, polarity from edge-select bit
	logic pin_prev_reg; // Previous agreed level
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			pin_prev_reg <= 1'b0;
		else
			pin_prev_reg <= pin_level_reg;
	end

	assign pin_edge = option_config_reg[ebtsp_pkg::OPT_EDGE_SEL_BIT]
		? (pin_prev_reg && !pin_level_reg) : (!pin_prev_reg && pin_level_reg);

	// Source mux: instruction cycle or pin edge
	assign src_tick = option_config_reg[ebtsp_pkg::OPT_SOURCE_SEL_BIT] ? pin_edge : cyc_tick;

	// ****************************************
	// Shared prescaler
	// ****************************************
	// Input is whichever unit owns it; clear by owner's instruction
	ebtsp_prescaler #(.WIDTH(8)) u_presc
	(
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.tick_i(to_wdt ? cyc_tick : src_tick),
		.clear_i(to_wdt ? wdt_clr : wr_count),
		.cfg_i(presc_cfg),
		.tap_o(presc_out)
	);

	// Watchdog tick is prescaled only when it owns the prescaler
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			wdt_tick_reg <= 1'b0;
		else
			wdt_tick_reg <= to_wdt ? presc_out : cyc_tick;
	end

	assign watchdog_tick_o = wdt_tick_reg;

	// Timer input, before phase sampling
	logic tmr_in; // Prescaled or raw source event
	assign tmr_in = to_wdt ? src_tick : presc_out;

	// Hold events as a level until the next Q2/Q4 takes it
	// An event at Q2/Q4 is used at once; holding it too would count twice
	logic ev_hold_reg; // Pending event
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i || sleep_reg)
			ev_hold_reg <= 1'b0;
		else if (q24)
			ev_hold_reg <= 1'b0;
		else if (tmr_in)
			ev_hold_reg <= 1'b1;
	end

	// Counter increments once per sampled event, not during a write hold
	assign cnt_tick = q24 && (ev_hold_reg || tmr_in) && (inhibit_reg == 2'h0)
		&& !sleep_reg && !wr_count;
	assign wrap = cnt_tick && (timer_count_reg == ebtsp_pkg::COUNT_MAX);

	// ****************************************
	// Write inhibit
	// ****************************************
	// Two instruction cycles of hold after any count write
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			inhibit_reg <= 2'h0;
		else if (wr_count)
			inhibit_reg <= 2'(ebtsp_pkg::WRITE_INHIBIT_CYCLES);
		else if (cyc_tick && inhibit_reg != 2'h0)
			inhibit_reg <= inhibit_reg - 2'h1;
	end

	// ****************************************
	// Count register
	// ****************************************
	// Write wins over increment
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			timer_count_reg <= ebtsp_pkg::TIMER_COUNT_RST;
		else if (wr_count)
			timer_count_reg <= hwdata_i[7:0];
		else if (cnt_tick)
			timer_count_reg <= timer_count_reg + 8'h01;
	end

	// Option register; only bus writes change ownership
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			option_config_reg <= ebtsp_pkg::OPTION_CONFIG_RST;
		else if (wr_opt)
			option_config_reg <= hwdata_i[7:0];
	end

	// ****************************************
	// Interrupt control
	// ****************************************
	// Flag set by wrap wins over a software clear
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			interrupt_control_reg <= ebtsp_pkg::INTERRUPT_CONTROL_RST;
		else
		begin
			if (wr_pend_reg && wr_idx_reg == ebtsp_pkg::INTERRUPT_CONTROL_IDX)
				interrupt_control_reg <= hwdata_i[7:0];
			if (wrap)
				interrupt_control_reg[ebtsp_pkg::IC_OVF_FLAG_BIT] <= 1'b1;
		end
	end

	// Sleep and enable registers
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			sleep_reg <= 1'b0;
			irq_enable_reg <= 1'b0;
		end
		else
		begin
			if (wr_pend_reg && wr_idx_reg == ebtsp_pkg::CORE_CTRL_IDX)
				sleep_reg <= hwdata_i[ebtsp_pkg::CTRL_SLEEP_BIT];
			if (wr_pend_reg && wr_idx_reg == ebtsp_pkg::IRQ_ENABLE_IDX)
				irq_enable_reg <= hwdata_i[0];
		end
	end

	// Sticky event status; set wins over clear
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			irq_status_reg <= 1'b0;
		else if (wrap)
			irq_status_reg <= 1'b1;
		else if (wr_pend_reg && wr_idx_reg == ebtsp_pkg::IRQ_CLEAR_IDX && hwdata_i[0])
			irq_status_reg <= 1'b0;
	end

	// Level interrupt: overflow flag masked by its enable, sticky status by the event enable (flags untouched)
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			irq_reg <= 1'b0;
		else
			irq_reg <= (interrupt_control_reg[ebtsp_pkg::IC_OVF_IE_BIT]
				&& interrupt_control_reg[ebtsp_pkg::IC_OVF_FLAG_BIT])
				|| (irq_enable_reg && irq_status_reg);
	end

	assign irq_o = irq_reg;

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_count_write;
		wr_count;
	endsequence

	sequence s_hold;
		!cnt_tick [*6];
	endsequence

	AST_WRITE_HOLD: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		s_count_write |=> s_hold)
		else $error("count advanced during write hold");
	AST_WRAP_FLAG: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		wrap |=> interrupt_control_reg[ebtsp_pkg::IC_OVF_FLAG_BIT])
		else $error("wrap did not set flag");
	AST_IRQ_MASK: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!interrupt_control_reg[ebtsp_pkg::IC_OVF_IE_BIT] && !irq_enable_reg |=> !irq_o)
		else $error("irq while masked");
	AST_SLEEP_FREEZE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		sleep_reg && !wr_count |=> $stable(timer_count_reg))
		else $error("count moved in sleep");
	AST_Q_SAMPLE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!wr_count && !phase_reg[0] |=> $stable(timer_count_reg))
		else $error("count outside Q2/Q4");
	AST_PRESC_CLEAR: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		wr_count && !to_wdt |=> u_presc.count_reg == 8'h00)
		else $error("prescaler not cleared");
	AST_OWNER_KEEP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		wr_count |=> $stable(to_wdt))
		else $error("ownership changed by count write");
	AST_WDT_CLEAR: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		wdt_clr && to_wdt |=> u_presc.count_reg == 8'h00)
		else $error("watchdog clear missed prescaler");

endmodule

// ==== verif/ebtsp_pin_source.sv ====
`timescale 1ns/1ps

// ****************************************
// External count source on the count pin
// ****************************************
module ebtsp_pin_source
(
	input wire logic clk_sys_i,
	output logic pin_o
)
;
	// Pin idles low until the first burst
	initial
	begin
		pin_o = 1'b0;
	end

	// Toggle the pin n times; each level lasts half clocks
	// Half is kept well above the two-clock Q2/Q4 sampling window
	task automatic toggle(input int n, input int half);
		for (int i = 0; i < n; i++)
		begin
			repeat (half) @(posedge clk_sys_i);
			pin_o <= ~pin_o;
		end
		// Last level held long enough to be sampled
		repeat (half) @(posedge clk_sys_i);
	endtask
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ps

`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (e)); end end

module tb;
	// ****************************************
	// Signals
	// ****************************************
	logic clk_sys_i = 1'b0; // 200 MHz system clock
	logic reset_i = 1'b1; // Synchronous reset
	logic hsel = 1'b0, hwrite = 1'b0, hready; // Bus control
	logic [1:0] htrans = 2'b00; // Transfer kind
	logic [2:0] hsize = 3'b010; // Always a word
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata; // Address and data
	logic pin, wd_tick, irq, hresp; // Count pin, watchdog tick, interrupt, response
	logic [31:0] r; // Last read word
	int bad_count = 0, comparisons = 0, ticks = 0, t0, n, h; // Bookkeeping

	always #2.5 clk_sys_i = ~clk_sys_i;

	ebtsp_timer u_ebtsp_timer (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
		.hresp_o(hresp), .ext_count_input_i(pin), .watchdog_tick_o(wd_tick), .irq_o(irq));

	ebtsp_pin_source u_src (.clk_sys_i(clk_sys_i), .pin_o(pin));

	// Watchdog ticks counted for the ratio check
	always @(posedge clk_sys_i)
	begin
		if (wd_tick === 1'b1)
			ticks++;
	end

	// ****************************************
	// Bus tasks
	// ****************************************
	// Single word transfer; waits for ready in both phases
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk_sys_i); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk_sys_i); while (hready !== 1'b1);
		r = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [31:0] a);
		xfer(1'b0, a, 32'h0);
	endtask

	// Tolerance of one count for sampling latency
	function automatic logic near(input logic [7:0] a, input logic [7:0] e);
		return (a >= e - 8'h01) && (a <= e + 8'h01);
	endfunction

	// Selected edges produced by n toggles from a start level
	function automatic int edges(input logic lvl, input int n, input logic fall);
		int c = 0;
		for (int i = 0; i < n; i++)
		begin
			lvl = ~lvl;
			if (lvl == ~fall)
				c++;
		end
		return c;
	endfunction

	// ****************************************
	// Verdict
	// ****************************************
	task automatic results();
		if (bad_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Hang guard, well beyond the roughly 17000 cycles the tests need
	initial
	begin
		repeat (50000) @(posedge clk_sys_i);
		bad_count++;
		results();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		void'($urandom(32'h9B40));
		repeat (6) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		// Reset values and an unmapped place
		rd(32'h004); `CHK(r[7:0], 8'h00)
		rd(32'h02C); `CHK(r[7:0], 8'h00)
		rd(32'h204); `CHK(r[7:0], 8'hFF)
		wr(32'h008, 32'hFF);
		rd(32'h008); `CHK(r, 32'h0)
		`CHK(hresp, 1'b0)
		// Timer mode, prescaler with watchdog, random start
		wr(32'h204, 32'h08);
		n = $urandom_range(0, 200);
		wr(32'h004, n);
		rd(32'h004); `CHK(r[7:0], n[7:0])
		repeat (40) @(posedge clk_sys_i);
		rd(32'h004); `CHK(near(r[7:0], n[7:0] + 8'd9), 1'b1)
		// Every ratio with the prescaler on the counter
		for (int k = 0; k < 8; k++)
		begin
			wr(32'h204, k);
			wr(32'h004, 32'h0);
			repeat (((2 << k) * 4 + 2) * 4 - 6) @(posedge clk_sys_i);
			rd(32'h004); `CHK(near(r[7:0], 8'd4), 1'b1)
			rd(32'h204); `CHK(r[7:0], k[7:0])
		end
		// Overflow with both enables, then masking and clearing
		wr(32'h204, 32'h08);
		wr(32'h408, 32'h1);
		wr(32'h02C, 32'h20);
		wr(32'h004, 32'hFE);
		repeat (40) @(posedge clk_sys_i);
		rd(32'h02C); `CHK(r[7:0], 8'h24)
		rd(32'h400); `CHK(r[0], 1'b1)
		`CHK(irq, 1'b1)
		// Overflow enable alone still raises the line
		wr(32'h408, 32'h0);
		repeat (3) @(posedge clk_sys_i);
		`CHK(irq, 1'b1)
		wr(32'h02C, 32'h04);
		repeat (3) @(posedge clk_sys_i);
		`CHK(irq, 1'b0)
		wr(32'h408, 32'h1);
		repeat (3) @(posedge clk_sys_i);
		`CHK(irq, 1'b1)
		rd(32'h02C); `CHK(r[2], 1'b1)
		// Software clears the flag before enabling again
		wr(32'h02C, 32'h00);
		wr(32'h404, 32'h1);
		rd(32'h400); `CHK(r[0], 1'b0)
		wr(32'h02C, 32'h20);
		repeat (3) @(posedge clk_sys_i);
		`CHK(irq, 1'b0)
		// Sleep freezes the count
		wr(32'h40C, 32'h1);
		rd(32'h004);
		t0 = r[7:0];
		repeat (100) @(posedge clk_sys_i);
		rd(32'h004); `CHK(r[7:0], t0[7:0])
		wr(32'h40C, 32'h0);
		// Pin counting on rising, then falling edges
		for (int e = 0; e < 2; e++)
		begin
			wr(32'h204, e ? 32'h38 : 32'h28);
			wr(32'h004, 32'h0);
			repeat (12) @(posedge clk_sys_i);
			t0 = pin;
			n = $urandom_range(1, 9);
			h = $urandom_range(6, 12);
			u_src.toggle(n, h);
			rd(32'h004); `CHK(r[7:0], edges(t0[0], n, e[0]))
		end
		// Safe move of the prescaler to the watchdog
		wr(32'h204, 32'h01);
		wr(32'h004, 32'h0);
		wr(32'h204, 32'h09);
		wr(32'h40C, 32'h2);
		wr(32'h204, 32'h08);
		t0 = ticks;
		repeat (4000) @(posedge clk_sys_i);
		n = ticks - t0;
		wr(32'h204, 32'h09);
		wr(32'h40C, 32'h2);
		t0 = ticks;
		repeat (4000) @(posedge clk_sys_i);
		h = (ticks - t0) * 2;
		`CHK((h <= n + 2) && (h + 2 >= n), 1'b1)
		results();
	end
endmodule
